/* logic/acd_defs.vh */
// Purpose: shared constants of the serial command decoder
// Assumes: included by bare name from every design file
// Notes: definitions only
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH

// Command byte fields
`define ACD_OP_HI        7
`define ACD_OP_LO        5
`define ACD_MUL_BIT      4
`define ACD_ADDR_HI      3
`define ACD_ADDR_LO      0

// Operation codes
`define ACD_OP_DIRECT0   3'h0
`define ACD_OP_CHAN_RD   3'h1
`define ACD_OP_REG_RD    3'h2
`define ACD_OP_REG_WR    3'h3
`define ACD_OP_PULSE     3'h4
`define ACD_OP_RESERVED  3'h5
`define ACD_OP_RESET     3'h6
`define ACD_OP_DIRECT7   3'h7

// Register indices and defaults
`define ACD_NUM_RW_REGS  9
`define ACD_REG_LAST     4'h9
`define ACD_REG_ID       4'h9
`define ACD_DEF_R0       8'h0A
`define ACD_DEF_R1       8'h83
`define ACD_DEF_R2       8'h00
`define ACD_DEF_R3       8'h00
`define ACD_DEF_R4       8'hFF
`define ACD_DEF_R5       8'hFF
`define ACD_DEF_R6       8'h00
`define ACD_DEF_R7       8'hFF
`define ACD_DEF_R8       8'h00
// Identity value is arbitrary
`define ACD_ID_VALUE     8'h5A

// Field positions of register 0 and register 6
`define ACD_CFG0_SPIRST  6
`define ACD_CFG0_FIXED   5
`define ACD_CFG0_STAT    1
`define ACD_SYS_OFFSET   0
`define ACD_SYS_SUPPLY   2
`define ACD_SYS_TEMP     3
`define ACD_SYS_SPARE    4
`define ACD_SYS_REF      5

// Channel tags
`define ACD_TAG_DIFF0    5'h00
`define ACD_TAG_SE0      5'h08
`define ACD_TAG_OFFSET   5'h18
`define ACD_TAG_SUPPLY   5'h1A
`define ACD_TAG_TEMP     5'h1B
`define ACD_TAG_SPARE    5'h1C
`define ACD_TAG_REF      5'h1D
`define ACD_TAG_BEFORE0  5'h1F

// Serial-clock inactivity limits in mclk cycles
`define ACD_TMO_LONG     13'h1000
`define ACD_TMO_SHORT    13'h0100

`endif

/* logic/acd_regfile.v */
// Purpose: register store of the command decoder, nine writable bytes and an identity byte
// Assumes: write and read ports driven from flops on mclk
// Notes: read data is registered, valid one cycle after the address changes
`include "acd_defs.vh"
`default_nettype none
module acd_regfile (
	input  wire        mclk,
	input  wire        rst,
	input  wire        ce,
	input  wire        clr,
	input  wire        we,
	input  wire [3:0]  waddr,
	input  wire [7:0]  wdata,
	input  wire [3:0]  raddr,
	output reg  [7:0]  rdata_q,
	output wire [71:0] regs_flat
);

	reg     [7:0] mem_q [0:8];
	integer       i;
	genvar        g;

	function [7:0] dflt;
		input [3:0] a;
		begin
			case (a)
				4'h0:    dflt = `ACD_DEF_R0;
				4'h1:    dflt = `ACD_DEF_R1;
				4'h2:    dflt = `ACD_DEF_R2;
				4'h3:    dflt = `ACD_DEF_R3;
				4'h4:    dflt = `ACD_DEF_R4;
				4'h5:    dflt = `ACD_DEF_R5;
				4'h6:    dflt = `ACD_DEF_R6;
				4'h7:    dflt = `ACD_DEF_R7;
				default: dflt = `ACD_DEF_R8;
			endcase
		end
	endfunction

	// Reset takes priority over the clock enable so a frozen block can still be cleared
	always @(posedge mclk)
	begin
		if (rst)
		begin
			for (i = 0; i < `ACD_NUM_RW_REGS; i = i + 1)
				mem_q[i] <= dflt(i[3:0]);
			rdata_q <= 8'h00;
		end
		else if (ce)
		begin
			if (clr)
			begin
				for (i = 0; i < `ACD_NUM_RW_REGS; i = i + 1)
					mem_q[i] <= dflt(i[3:0]);
			end
			else if (we && (waddr < `ACD_REG_ID))
				mem_q[waddr] <= wdata;
			if (raddr == `ACD_REG_ID)
				rdata_q <= `ACD_ID_VALUE;
			else if (raddr < `ACD_REG_ID)
				rdata_q <= mem_q[raddr];
			else
				rdata_q <= 8'h00;
		end
	end

	generate
		for (g = 0; g < `ACD_NUM_RW_REGS; g = g + 1)
		begin : g_flat
			assign regs_flat[g*8 +: 8] = mem_q[g];
		end
	endgenerate

endmodule // acd_regfile
`default_nettype wire

/* logic/acd_spi_cmd.v */
// Purpose: serial command decoder and channel-data formatter for a scanning converter
// Assumes: cs_n, sclk, din are asynchronous pins; sclk idles low, input sampled on rise
// Notes: each sclk phase must last at least three mclk periods
// Contract
// [RL1] Each auto-scan result carries its channel tag
// [RL2] Results are 24-bit two's complement, MSB first
// [RL3] Auto-scan visits enabled channels in priority order
// [RL4] Differential 00h-07h, single-ended 08h-17h, offset 18h
// [RL5] Monitors use 1Ah, 1Bh, 1Ch, 1Dh lowest
// [RL6] Register commands carry following data bytes
// [RL7] Host ends direct reads before next command
// [RL8] Command channel read needs no chip-select toggle
// [RL9] Command byte: opcode, multi flag, register index
// [RL10] Codes 000 and 111 are direct reads
// [RL11] Code 001 returns framed data with status
// [RL12] 010 read, 011 write, 100 pulse convert
// [RL13] 110 resets device; 101 is reserved
// [RL14] Multi flag clear moves exactly one register
// [RL15] Register index increments after every data byte
// [RL16] Multi transfers end after register 09h
// [RL17] Chip-select release aborts transfer, resets interface
// [RL18] Idle serial clock 4096 cycles resets interface
// [RL19] Host sets multi flag for framed reads
// [RL20] Status byte first, then data MSB first
// [RL21] Fresh flag set on update, cleared by read
// [RL22] Reserved opcode is ignored entirely
`include "acd_defs.vh"
`default_nettype none
module acd_spi_cmd (
	input  wire        mclk,
	input  wire        rst,
	input  wire        ce,
	input  wire        cs_n,
	input  wire        sclk,
	input  wire        din,
	input  wire        sample_valid,
	input  wire [23:0] sample_data,
	input  wire        sample_over_range,
	input  wire        sample_low_supply,
	output wire        dout,
	output wire        dout_oe,
	output wire [4:0]  scan_channel,
	output wire        convert_pulse,
	output wire        reset_pulse,
	output wire        data_fresh,
	output wire [71:0] cfg_regs
);

	localparam [2:0] ST_CMD  = 3'h0;
	localparam [2:0] ST_RD   = 3'h1;
	localparam [2:0] ST_WR   = 3'h2;
	localparam [2:0] ST_CHAN = 3'h3;
	localparam [2:0] ST_LOCK = 3'h4;

	// Pin synchronisers
	reg        cs_s1_q;
	reg        cs_s2_q;
	reg        sclk_s1_q;
	reg        sclk_s2_q;
	reg        sclk_s3_q;
	reg        din_s1_q;
	reg        din_s2_q;

	// Link state
	reg [2:0]  state_q;
	reg [2:0]  bit_cnt_q;
	reg [1:0]  byte_cnt_q;
	reg [6:0]  rx_q;
	reg [31:0] out_sr_q;
	reg        load_pend_q;
	reg        idle_q;
	reg        oe_q;
	reg [3:0]  addr_q;
	reg        multi_reg_flag_q;
	reg [12:0] tmo_q;
	reg        we_q;
	reg [3:0]  waddr_q;
	reg [7:0]  wdata_q;
	reg        convert_q;
	reg        reset_q;

	// Result state
	reg [23:0] data_q;
	reg        over_range_flag_q;
	reg        low_supply_q;
	reg [4:0]  channel_tag_q;
	reg        fresh_q;
	reg [4:0]  scan_q;

	wire [7:0]  rdata;
	wire [71:0] regs;
	wire [7:0]  cfg0;
	wire [31:0] scan_mask;
	wire        fixed_mode;
	wire        sclk_rise;
	wire        sclk_fall;
	wire [12:0] tmo_limit;
	wire        tmo_hit;
	wire        iface_rst;
	wire        byte_end;
	wire [7:0]  rx_byte;
	wire [2:0]  op;
	wire        last_byte;
	wire [4:0]  tag_out;
	wire [7:0]  status;
	wire        stat_en;
	wire [31:0] direct_word;
	wire        fresh_clr;

	// Enabled channels as one bit per tag, lowest index is highest priority
	function [31:0] build_mask;
		input [7:0] diff;
		input [7:0] se_lo;
		input [7:0] se_hi;
		input [7:0] sys;
		begin
			build_mask = {2'b00, sys[`ACD_SYS_REF], sys[`ACD_SYS_SPARE],       // RL5
				sys[`ACD_SYS_TEMP], sys[`ACD_SYS_SUPPLY], 1'b0,
				sys[`ACD_SYS_OFFSET], se_hi, se_lo, diff};                     // RL4
		end
	endfunction

	// Next enabled tag after cur, wrapping; holds cur when nothing is enabled
	function [4:0] next_tag;
		input [31:0] mask;
		input [4:0]  cur;
		integer      i;
		reg   [4:0]  k;
		reg          found;
		begin
			k = cur;
			found = 1'b0;
			next_tag = cur;
			for (i = 0; i < 32; i = i + 1)
			begin
				k = k + 5'h01;
				if (!found && mask[k])
				begin
					next_tag = k;                                           // RL3
					found = 1'b1;
				end
			end
		end
	endfunction

	assign cfg0       = regs[7:0];
	assign fixed_mode = cfg0[`ACD_CFG0_FIXED];
	assign scan_mask  = build_mask(regs[31:24], regs[39:32], regs[47:40], regs[55:48]);

	assign sclk_rise  = sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall  = ~sclk_s2_q & sclk_s3_q;
	assign tmo_limit  = cfg0[`ACD_CFG0_SPIRST] ? `ACD_TMO_SHORT : `ACD_TMO_LONG;
	assign tmo_hit    = ~idle_q & (tmo_q == (tmo_limit - 13'h0001));               // RL18
	assign iface_rst  = cs_s2_q | tmo_hit;                                         // RL17

	assign byte_end   = sclk_rise & (bit_cnt_q == 3'h7);
	assign rx_byte    = {rx_q, din_s2_q};
	assign op         = rx_byte[`ACD_OP_HI:`ACD_OP_LO];                           // RL9
	assign last_byte  = ~multi_reg_flag_q | (addr_q == `ACD_REG_LAST);             // RL16

	// Tag is meaningless in fixed-channel mode, so it reads as zero there
	assign tag_out     = fixed_mode ? 5'h00 : channel_tag_q;                      // RL1
	assign status      = {fresh_q, over_range_flag_q, low_supply_q, tag_out};      // RL20
	assign stat_en     = cfg0[`ACD_CFG0_STAT] & ~fixed_mode;
	assign direct_word = stat_en ? {status, data_q} : {data_q, 8'h00};             // RL2

	// A read of the result clears the fresh flag
	assign fresh_clr = ~iface_rst &
		((sclk_fall & load_pend_q & (state_q == ST_CHAN)) |
		 (byte_end & (state_q == ST_CMD) &
		  ((op == `ACD_OP_DIRECT0) | (op == `ACD_OP_DIRECT7))));                    // RL21

	always @(posedge mclk)
	begin
		if (rst)
		begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			din_s1_q  <= 1'b0;
			din_s2_q  <= 1'b0;
		end
		else if (ce)
		begin
			cs_s1_q   <= cs_n;
			cs_s2_q   <= cs_s1_q;
			sclk_s1_q <= sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			din_s1_q  <= din;
			din_s2_q  <= din_s1_q;
		end
	end

	// Command and transfer engine
	always @(posedge mclk)
	begin
		if (rst)
		begin
			state_q          <= ST_CMD;
			bit_cnt_q        <= 3'h0;
			byte_cnt_q       <= 2'h0;
			rx_q             <= 7'h00;
			out_sr_q         <= 32'h00000000;
			load_pend_q      <= 1'b0;
			idle_q           <= 1'b1;
			oe_q             <= 1'b0;
			addr_q           <= 4'h0;
			multi_reg_flag_q <= 1'b0;
			tmo_q            <= 13'h0000;
			we_q             <= 1'b0;
			waddr_q          <= 4'h0;
			wdata_q          <= 8'h00;
			convert_q        <= 1'b0;
			reset_q          <= 1'b0;
		end
		else if (ce)
		begin
			oe_q      <= ~cs_s2_q;
			we_q      <= 1'b0;
			convert_q <= 1'b0;
			reset_q   <= 1'b0;
			if (sclk_rise | sclk_fall | idle_q)
				tmo_q <= 13'h0000;
			else
				tmo_q <= tmo_q + 13'h0001;
			if (iface_rst)
			begin
				state_q     <= ST_CMD;                                         // RL17
				bit_cnt_q   <= 3'h0;
				byte_cnt_q  <= 2'h0;
				load_pend_q <= 1'b0;
				idle_q      <= 1'b1;
				out_sr_q    <= direct_word;
			end
			else
			begin
				// Direct data stays current until the first clock edge
				if (idle_q && !sclk_rise)
					out_sr_q <= direct_word;
				else if (sclk_fall)
				begin
					if (load_pend_q && (state_q == ST_CHAN))
						out_sr_q <= {status, data_q};                          // RL20
					else if (load_pend_q)
						out_sr_q <= {rdata, 24'h000000};                       // RL6
					else
						out_sr_q <= {out_sr_q[30:0], 1'b0};
					load_pend_q <= 1'b0;
				end
				if (sclk_rise)
				begin
					idle_q    <= 1'b0;
					rx_q      <= rx_byte[6:0];
					bit_cnt_q <= bit_cnt_q + 3'h1;
				end
				if (byte_end)
				begin
					case (state_q)
						ST_CMD:
						begin
							multi_reg_flag_q <= rx_byte[`ACD_MUL_BIT];         // RL9
							addr_q <= rx_byte[`ACD_ADDR_HI:`ACD_ADDR_LO];       // RL15
							case (op)
								`ACD_OP_DIRECT0, `ACD_OP_DIRECT7:
									state_q <= ST_LOCK;                         // RL10
								`ACD_OP_CHAN_RD:
								begin
									state_q     <= ST_CHAN;                     // RL11
									byte_cnt_q  <= 2'h0;
									load_pend_q <= 1'b1;                        // RL8
								end
								`ACD_OP_REG_RD:
								begin
									state_q     <= ST_RD;                       // RL12
									load_pend_q <= 1'b1;
								end
								`ACD_OP_REG_WR:
									state_q <= ST_WR;                           // RL12
								`ACD_OP_PULSE:
									convert_q <= 1'b1;                          // RL12
								`ACD_OP_RESET:
									reset_q <= 1'b1;                            // RL13
								default:
									state_q <= ST_CMD;                          // RL22
							endcase
						end
						ST_RD:
						begin
							if (last_byte)
								state_q <= ST_CMD;                              // RL14
							else
							begin
								addr_q      <= addr_q + 4'h1;                   // RL15
								load_pend_q <= 1'b1;
							end
						end
						ST_WR:
						begin
							we_q    <= 1'b1;                                    // RL6
							waddr_q <= addr_q;
							wdata_q <= rx_byte;
							if (last_byte)
								state_q <= ST_CMD;                              // RL16
							else
								addr_q <= addr_q + 4'h1;                        // RL15
						end
						ST_CHAN:
						begin
							byte_cnt_q <= byte_cnt_q + 2'h1;
							if (byte_cnt_q == 2'h3)
								state_q <= ST_CMD;                              // RL19
						end
						ST_LOCK:
							state_q <= ST_LOCK;
						default:
							state_q <= ST_CMD;
					endcase
				end
			end
		end
	end

	// Result capture and scan sequencing
	always @(posedge mclk)
	begin
		if (rst)
		begin
			data_q            <= 24'h000000;
			over_range_flag_q <= 1'b0;
			low_supply_q      <= 1'b0;
			channel_tag_q     <= 5'h00;
			fresh_q           <= 1'b0;
			scan_q            <= 5'h00;
		end
		else if (ce)
		begin
			if (sample_valid)
			begin
				data_q            <= sample_data;                              // RL2
				over_range_flag_q <= sample_over_range;
				low_supply_q      <= sample_low_supply;
				channel_tag_q     <= scan_q;                                   // RL1
				scan_q            <= next_tag(scan_mask, scan_q);              // RL3
				fresh_q           <= 1'b1;                                     // RL21
			end
			else if (fresh_clr)
				fresh_q <= 1'b0;
			// Registers clear in this same cycle, so restart from the default channel set
			if (reset_q)
				scan_q <= next_tag(build_mask(`ACD_DEF_R3, `ACD_DEF_R4, `ACD_DEF_R5,
					`ACD_DEF_R6), `ACD_TAG_BEFORE0);                             // RL13
		end
	end

	acd_regfile u_regs (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.clr       (reset_q),
		.we        (we_q),
		.waddr     (waddr_q),
		.wdata     (wdata_q),
		.raddr     (addr_q),
		.rdata_q   (rdata),
		.regs_flat (regs)
	);

	assign dout          = out_sr_q[31];
	assign dout_oe       = oe_q;
	assign scan_channel  = scan_q;
	assign convert_pulse = convert_q;
	assign reset_pulse   = reset_q;
	assign data_fresh    = fresh_q;
	assign cfg_regs      = regs;

endmodule // acd_spi_cmd
`default_nettype wire

/* verification/acd_spi_cmd_checker.sv */
// Purpose: concurrent checks on the ports of the serial command decoder
// Assumes: one mclk domain, rst synchronous and active high
// Notes: pins pass a two-flop sync, so levels are held a few cycles before judging
`default_nettype none
module acd_spi_cmd_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic        din,
	input wire logic        sample_valid,
	input wire logic [23:0] sample_data,
	input wire logic        sample_over_range,
	input wire logic        sample_low_supply,
	input wire logic        dout,
	input wire logic        dout_oe,
	input wire logic [4:0]  scan_channel,
	input wire logic        convert_pulse,
	input wire logic        reset_pulse,
	input wire logic        data_fresh,
	input wire logic [71:0] cfg_regs
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [71:0] DEF_REGS = 72'h00FF00FFFF0000830A;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	oe_on_a: assert property ((ce && !cs_n) [*4] |-> dout_oe)
		else $error("output enable missing while selected");
	oe_off_a: assert property ((ce && cs_n) [*4] |-> !dout_oe)
		else $error("output enable while deselected");
	pulse_single_a: assert property (convert_pulse |=> !convert_pulse)
		else $error("convert pulse longer than one cycle");
	reset_regs_a: assert property (reset_pulse |-> ##[0:2] (cfg_regs == DEF_REGS))
		else $error("reset command left registers changed");
	rst_state_a: assert property ($fell(rst) |-> (cfg_regs == DEF_REGS) && !dout_oe
		&& !data_fresh && (scan_channel == 5'h00)) else $error("wrong state after reset");
	fresh_set_a: assert property (ce && sample_valid |=> data_fresh)
		else $error("fresh flag not set by new result");
	quiet_pulse_a: assert property ((ce && cs_n) [*6] |-> !convert_pulse && !reset_pulse)
		else $error("command pulse while deselected");
	cfg_hold_a: assert property ((ce && cs_n) [*6] |=> $stable(cfg_regs))
		else $error("registers changed while deselected");
	fresh_keep_a: assert property ((ce && cs_n) [*4] ##0 data_fresh |=> data_fresh)
		else $error("fresh flag lost while deselected");
	freeze_hold_a: assert property (!ce |=> $stable(scan_channel) && $stable(data_fresh)
		&& $stable(cfg_regs) && $stable(dout_oe) && $stable(dout))
		else $error("state moved while clock enable low");
endmodule // acd_spi_cmd_checker
bind acd_spi_cmd acd_spi_cmd_checker i_acd_spi_cmd_checker (
	.mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n), .sclk(sclk), .din(din),
	.sample_valid(sample_valid), .sample_data(sample_data), .dout(dout),
	.sample_over_range(sample_over_range), .sample_low_supply(sample_low_supply),
	.dout_oe(dout_oe), .scan_channel(scan_channel), .convert_pulse(convert_pulse),
	.reset_pulse(reset_pulse), .data_fresh(data_fresh), .cfg_regs(cfg_regs)
);
`default_nettype wire

/* verification/acd_host.sv */
// Purpose: host side of the serial link, a mode 0 master paced by mclk
// Assumes: eight mclk per sclk period, 400 ns at 20 MHz
// Notes: sclk stands low outside frames; din toggles on every select change
`default_nettype none
module acd_host (
	input  wire logic mclk,
	input  wire logic dout,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic din
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {cs_n, sclk, din} = 3'b100;
	task automatic half;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// Deselect is the only way out of a direct read short of the idle timeout
	task automatic select(input logic lvl);
		half();
		cs_n = lvl;
		din = ~din;
		half();
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			din = tx[i];
			half();
			rx[i] = dout;
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
	endtask
endmodule // acd_host
`default_nettype wire

/* verification/tb_acd_spi_cmd.sv */
// Purpose: self-checking bench of the serial command decoder
// Assumes: acd_host drives the link, the bench feeds conversion results
// Notes: sclk idles past both timeouts; clock enable drops once; reset repeats at the end
`include "acd_defs.vh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_acd_spi_cmd;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [71:0] DEF_REGS = 72'h00FF00FFFF0000830A;
	logic        mclk, rst, ce, cs_n, sclk, din, dout, dout_oe;
	logic        sample_valid, sample_over_range, sample_low_supply;
	logic        convert_pulse, reset_pulse, data_fresh;
	logic [23:0] sample_data;
	logic [4:0]  scan_channel;
	logic [71:0] cfg_regs;
	logic [7:0]  r;
	logic [25:0] v;
	logic [4:0]  tags [6] = '{5'h18, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h18};
	int          num_errors = 0;
	int          tests_run = 0;
	int          n_conv = 0;
	int          n_rst = 0;
	int          c;
	acd_spi_cmd i_acd_spi_cmd (
		.mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n), .sclk(sclk), .din(din),
		.sample_valid(sample_valid), .sample_data(sample_data), .dout(dout),
		.sample_over_range(sample_over_range), .sample_low_supply(sample_low_supply),
		.dout_oe(dout_oe), .scan_channel(scan_channel), .convert_pulse(convert_pulse),
		.reset_pulse(reset_pulse), .data_fresh(data_fresh), .cfg_regs(cfg_regs)
	);
	acd_host i_acd_host (.mclk(mclk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) n_conv += int'(convert_pulse === 1'b1);
	always @(posedge mclk) n_rst += int'(reset_pulse === 1'b1);
	task automatic send(input logic [7:0] b);
		logic [7:0] x;
		i_acd_host.xfer(b, x);
	endtask
	task automatic rd_chk(input logic [7:0] e);
		logic [7:0] x;
		i_acd_host.xfer(8'h00, x);
		`CHK(x, e)
	endtask
	task automatic sample(input logic [25:0] s);
		sample_valid = 1'b1;
		{sample_over_range, sample_low_supply, sample_data} = s;
		@(posedge mclk);
		#1;
		sample_valid = 1'b0;
	endtask
	task automatic summarize;
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge mclk);
		num_errors++;
		summarize();
	end
	initial
	begin
		{rst, ce, sample_valid, sample_over_range, sample_low_supply} = 5'b11000;
		sample_data = 24'h000000;
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		`CHK(cfg_regs, DEF_REGS)
		i_acd_host.select(1'b0);
		send(8'h63);
		send(8'h5C);
		send(8'h43);
		rd_chk(8'h5C);
		send(8'h44);
		rd_chk(8'hFF);
		send(8'h77);
		send(8'h11);
		send(8'h22);
		send(8'h33);
		send(8'h58);
		rd_chk(8'h22);
		rd_chk(`ACD_ID_VALUE);
		send(8'h47);
		rd_chk(8'h11);
		c = n_conv;
		send(8'h9F);
		send(8'hB3);
		send(8'h43);
		rd_chk(8'h5C);
		send(8'hDF);
		i_acd_host.select(1'b1);
		`CHK(n_conv - c, 1)
		`CHK(n_rst, 1)
		`CHK(cfg_regs, DEF_REGS)
		`CHK(scan_channel, `ACD_TAG_SE0)
		// Aborted multi write: the next byte must be taken as a command
		i_acd_host.select(1'b0);
		send(8'h71);
		send(8'h55);
		i_acd_host.select(1'b1);
		i_acd_host.select(1'b0);
		send(8'h42);
		rd_chk(8'h00);
		`CHK(cfg_regs[15:8], 8'h55)
		send(8'h72);
		send(8'h66);
		repeat (4200) @(posedge mclk);
		#1;
		send(8'h43);
		rd_chk(8'h00);
		`CHK(cfg_regs[31:16], 16'h0066)
		send(8'h60);
		send(8'h4A);
		send(8'h72);
		send(8'h77);
		repeat (300) @(posedge mclk);
		#1;
		send(8'h43);
		rd_chk(8'h00);
		`CHK(cfg_regs[23:16], 8'h77)
		send(8'h60);
		send(8'h0A);
		v = 26'h2A5C396;
		sample(v);
		`CHK(scan_channel, 5'h09)
		for (int k = 1; k >= 0; k--)
		begin
			send(8'h30);
			rd_chk({k[0], v[25:24], `ACD_TAG_SE0});
			rd_chk(v[23:16]);
			rd_chk(v[15:8]);
			rd_chk(v[7:0]);
		end
		send(8'h73);
		send(8'h00);
		send(8'h00);
		send(8'h00);
		send(8'h3D);
		i_acd_host.select(1'b1);
		foreach (tags[j])
		begin
			sample(26'h1800000);
			`CHK(scan_channel, tags[j])
		end
		ce = 1'b0;
		sample(26'h0000000);
		ce = 1'b1;
		`CHK(scan_channel, tags[5])
		`CHK(data_fresh, 1'b1)
		for (int k = 0; k < 2; k++)
		begin
			c = n_conv;
			v = k ? 26'h1800001 : 26'h27FFFFF;
			sample(v);
			i_acd_host.select(1'b0);
			i_acd_host.xfer(k ? 8'hFF : 8'h1F, r);
			`CHK(r, {1'b1, v[25:24], tags[k]})
			rd_chk(v[23:16]);
			rd_chk(v[15:8]);
			rd_chk(v[7:0]);
			send(8'h9F);
			i_acd_host.select(1'b1);
			`CHK(n_conv - c, 0)
			`CHK(data_fresh, 1'b0)
		end
		c = n_conv;
		i_acd_host.select(1'b0);
		send(8'h80);
		i_acd_host.select(1'b1);
		`CHK(n_conv - c, 1)
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		`CHK(cfg_regs, DEF_REGS)
		`CHK(scan_channel, 5'h00)
		summarize();
	end
endmodule // tb_acd_spi_cmd
`default_nettype wire
